// ==== verilog/boot_pkg.sv ====
// Shared constants and helpers for the serial boot link
package boot_pkg;

   // Link framing and command codes
   localparam logic [7:0] SYNC_BYTE = 8'h86;
   localparam logic [7:0] CMD_RAM = 8'h10;
   localparam logic [7:0] CMD_SUM = 8'h20;
   localparam logic [7:0] CMD_INFO = 8'h30;
   localparam logic [7:0] CMD_PROTECT = 8'h60;

   // Low nibble of acknowledge bytes
   localparam logic [3:0] ACK_RX_ERR = 4'h8;
   localparam logic [3:0] ACK_FAIL = 4'h1;
   localparam logic [3:0] ACK_OK = 4'h0;

   // Byte values with special meaning
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam logic [7:0] CHECK_OK = 8'h00;

   // Flash layout: password area followed directly by reset vector
   localparam logic [23:0] FLASH_BASE = 24'h040000;
   localparam logic [23:0] PW_ADDR = 24'h04fef4;
   localparam int PW_LEN = 12;
   localparam int VEC_LEN = 3;
   localparam int FLASH_BYTES = 262144;

   // Baud detection: first to third edge of the sync byte is 4 bits
   localparam int AC_BITS_LOG2 = 2;
   localparam int TOL_SHIFT = 3;
   localparam int TIMER_W = 20;
   localparam int BIT_W = 16;

   // Two's complement of an 8-bit running sum
   function automatic logic [7:0] frame_check(input logic [7:0] sum8);
      return 8'h00 - sum8;
   endfunction : frame_check

endpackage : boot_pkg

// ==== verilog/boot_link_if.sv ====
// Two-wire serial link between boot controller and device
`timescale 1ns/100ps
interface boot_link_if;
   logic to_dev;
   logic to_host;
   modport dev (input to_dev, output to_host);
   modport host (output to_dev, input to_host);
endinterface : boot_link_if

// ==== verilog/uart_byte.sv ====
// Byte-wide serial transmitter and receiver, 8N1, run-time bit period
`timescale 1ns/100ps
module uart_byte
   import boot_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [BIT_W-1:0] bit_cycles_i,
   input wire logic rx_en_i,
   input wire logic rxd_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic txd_o,
   output logic rx_level_o,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_err_o
);

   typedef struct packed {
      logic busy;
      logic [BIT_W-1:0] cnt;
      logic [3:0] bits;
      logic [9:0] sh;
      logic valid;
      logic err;
      logic line;
   } ser_t;

   logic [1:0] sync_r;
   ser_t rx_r, rx_nxt, tx_r, tx_nxt;
   logic [BIT_W-1:0] reload;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser on the receive pin
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_r <= 2'h3;
      end else begin
         sync_r <= {sync_r[0], rxd_i};
      end
   end

   assign rx_level_o = sync_r[1];
   assign reload = bit_cycles_i - 16'h0001;

   ////////////////////////////////////////////////////////////////////////
   // Receiver: half-bit to start centre, then full bits
   always_comb begin
      rx_nxt = rx_r;
      rx_nxt.valid = 1'b0;
      if (!rx_r.busy) begin
         if (rx_en_i && !sync_r[1]) begin
            rx_nxt.busy = 1'b1;
            rx_nxt.cnt = {1'b0, bit_cycles_i[BIT_W-1:1]};
            rx_nxt.bits = 4'h0;
         end
      end else if (rx_r.cnt != '0) begin
         rx_nxt.cnt = rx_r.cnt - 16'h0001;
      end else begin
         rx_nxt.cnt = reload;
         rx_nxt.bits = rx_r.bits + 4'h1;
         if (rx_r.bits == 4'h0) begin
            rx_nxt.busy = ~sync_r[1]; // Glitch, not a start bit
         end else if (rx_r.bits == 4'h9) begin
            rx_nxt.busy = 1'b0;
            rx_nxt.valid = 1'b1;
            rx_nxt.err = ~sync_r[1]; // Stop bit missing
         end else begin
            rx_nxt.sh = {2'h0, sync_r[1], rx_r.sh[7:1]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter: start, eight data bits LSB first, stop
   always_comb begin
      tx_nxt = tx_r;
      if (!tx_r.busy) begin
         if (tx_valid_i) begin
            tx_nxt.busy = 1'b1;
            tx_nxt.sh = {1'b1, tx_data_i, 1'b0};
            tx_nxt.cnt = reload;
            tx_nxt.bits = 4'h0;
            tx_nxt.line = 1'b0;
         end
      end else if (tx_r.cnt != '0) begin
         tx_nxt.cnt = tx_r.cnt - 16'h0001;
      end else if (tx_r.bits == 4'h9) begin
         tx_nxt.busy = 1'b0;
         tx_nxt.line = 1'b1;
      end else begin
         tx_nxt.cnt = reload;
         tx_nxt.bits = tx_r.bits + 4'h1;
         tx_nxt.sh = {1'b1, tx_r.sh[9:1]};
         tx_nxt.line = tx_r.sh[1];
      end
   end

   // State registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_r <= '0;
         tx_r <= '0;
         tx_r.line <= 1'b1;
      end else begin
         rx_r <= rx_nxt;
         tx_r <= tx_nxt;
      end
   end

   assign tx_ready_o = ~tx_r.busy;
   assign txd_o = tx_r.line;
   assign rx_data_o = rx_r.sh[7:0];
   assign rx_valid_o = rx_r.valid;
   assign rx_err_o = rx_r.err;

endmodule : uart_byte

// ==== verilog/boot_dev.sv ====
// Device end of the serial boot loader: baud sync, password, flash total
`timescale 1ns/100ps
module boot_dev
   import boot_pkg::*;
#(
   parameter int SUM_BYTES = FLASH_BYTES,
   parameter logic [BIT_W-1:0] MIN_BIT_CYCLES = 16'h0008,
   parameter logic [7:0] INFO_0 = 8'h5a, // Arbitrary value
   parameter logic [7:0] INFO_1 = 8'ha5 // Arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   boot_link_if.dev link,
   output logic [23:0] flash_addr_o,
   output logic flash_rd_o,
   input wire logic [7:0] flash_data_i,
   input wire logic flash_busy_i,
   output logic linked_o,
   output logic halted_o
);

   typedef enum logic [6:0] {
      S_BAUD = 7'h01,
      S_HALT = 7'h02,
      S_CMD = 7'h04,
      S_SEND = 7'h08,
      S_PWLOAD = 7'h10,
      S_PWRX = 7'h20,
      S_SUM = 7'h40
   } dev_state_t;

   localparam int PW_TOTAL = PW_LEN + VEC_LEN;
   localparam logic [18:0] SUM_END = 19'(SUM_BYTES);
   localparam logic [18:0] PW_END = 19'(PW_TOTAL);
   localparam logic [3:0] PW_LAST = 4'(PW_LEN);

   typedef struct packed {
      dev_state_t state;
      dev_state_t after;
      logic [1:0] edges;
      logic [TIMER_W-1:0] t_a;
      logic [TIMER_W-1:0] t_b;
      logic [BIT_W-1:0] bit_cyc;
      logic [7:0] cmd;
      logic [3:0][7:0] rep;
      logic [1:0] rep_last;
      logic [1:0] rep_i;
      logic [18:0] idx;
      logic rd;
      logic wt;
      logic [23:0] addr;
      logic [PW_TOTAL-1:0][7:0] stored;
      logic [15:0] total;
      logic [7:0] sum8;
      logic mism;
      logic same;
      logic [7:0] first;
      logic rxerr;
   } dev_regs_t;

   dev_regs_t st_r, st_nxt;
   logic [TIMER_W-1:0] timer_r;
   logic lvl_d_r;
   logic rx_level, rx_valid, rx_err, tx_ready, tx_valid;
   logic [7:0] rx_data, tx_data;
   logic [TIMER_W-1:0] t_ab2, t_ac, t_diff;
   logic baud_ok, blank, pw_err, edge_seen;
   logic [7:0] add8;
   logic [3:0] ack_lo;

   ////////////////////////////////////////////////////////////////////////
   // Serial engine, receiver held off until baud is known
   uart_byte u_uart (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .bit_cycles_i(st_r.bit_cyc),
      .rx_en_i(st_r.state != S_BAUD && st_r.state != S_HALT),
      .rxd_i(link.to_dev),
      .tx_data_i(tx_data),
      .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready),
      .txd_o(link.to_host),
      .rx_level_o(rx_level),
      .rx_data_o(rx_data),
      .rx_valid_o(rx_valid),
      .rx_err_o(rx_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Free-running timer and previous line level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_r <= '0;
         lvl_d_r <= 1'b1;
      end else begin
         timer_r <= timer_r + 20'h00001;
         lvl_d_r <= rx_level;
      end
   end

   assign edge_seen = rx_level ^ lvl_d_r;

   // Interval checks: 2*tAB must agree with tAC within tolerance
   assign t_ac = timer_r - st_r.t_a;
   assign t_ab2 = {st_r.t_b[TIMER_W-2:0] - st_r.t_a[TIMER_W-2:0], 1'b0};
   assign t_diff = (t_ab2 > t_ac) ? t_ab2 - t_ac : t_ac - t_ab2;
   assign baud_ok = (t_ac[TIMER_W-1:BIT_W+AC_BITS_LOG2] == '0) &&
                    (t_ac[BIT_W+AC_BITS_LOG2-1:AC_BITS_LOG2] >=
                     MIN_BIT_CYCLES) &&
                    (t_diff <= (t_ac >> TOL_SHIFT));

   // Password verdict from stored and received bytes
   assign blank = (st_r.stored[PW_LEN] == BLANK_BYTE) &&
                  (st_r.stored[PW_LEN+1] == BLANK_BYTE) &&
                  (st_r.stored[PW_LEN+2] == BLANK_BYTE);
   assign pw_err = st_r.mism ||
                   (st_r.same && !(st_r.first == BLANK_BYTE && blank));

   assign add8 = st_r.sum8 + rx_data;

   // receive error, then check byte, then password
   // check accepted when sum is zero
   always_comb begin
      if (st_r.rxerr || rx_err) begin
         ack_lo = ACK_RX_ERR;
      end else if (add8 != CHECK_OK || pw_err) begin
         ack_lo = ACK_FAIL;
      end else begin
         ack_lo = ACK_OK;
      end
   end

   assign tx_valid = (st_r.state == S_SEND);
   assign tx_data = st_r.rep[st_r.rep_i];

   ////////////////////////////////////////////////////////////////////////
   // Main sequencer next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.rd = 1'b0;
      unique case (st_r.state)
         // sync byte only measured, never decoded
         S_BAUD: begin
            if (edge_seen) begin
               st_nxt.edges = st_r.edges + 2'h1;
               unique case (st_r.edges)
                  2'h0: st_nxt.t_a = timer_r;
                  2'h1: st_nxt.t_b = timer_r;
                  2'h2: begin
                     st_nxt.bit_cyc = t_ac[BIT_W+AC_BITS_LOG2-1:AC_BITS_LOG2];
                     if (!baud_ok) begin
                        st_nxt.state = S_HALT;
                     end
                  end
                  2'h3: begin
                     st_nxt.rep[0] = SYNC_BYTE;
                     st_nxt.rep_last = 2'h0;
                     st_nxt.after = S_CMD;
                     st_nxt.state = S_SEND;
                  end
               endcase
            end
         end
         S_HALT: begin
         end
         S_CMD: begin
            if (rx_valid) begin
               st_nxt.cmd = rx_data;
               st_nxt.rep_last = 2'h0;
               st_nxt.after = S_CMD;
               st_nxt.idx = '0;
               st_nxt.wt = 1'b0;
               st_nxt.state = S_SEND;
               if (rx_err) begin
                  st_nxt.rep[0] = {rx_data[7:4], ACK_RX_ERR};
               end else if (rx_data == CMD_RAM || rx_data == CMD_PROTECT) begin
                  st_nxt.rep[0] = rx_data;
                  st_nxt.after = S_PWLOAD;
               end else if (rx_data == CMD_SUM) begin
                  st_nxt.rep[0] = rx_data;
                  st_nxt.total = '0;
                  st_nxt.after = S_SUM;
               end else if (rx_data == CMD_INFO) begin
                  // info reply ends in check byte
                  st_nxt.rep = {frame_check(INFO_0 + INFO_1), INFO_1,
                                INFO_0, rx_data};
                  st_nxt.rep_last = 2'h3;
               end else begin
                  st_nxt.rep[0] = {rx_data[7:4], ACK_FAIL};
               end
            end
         end
         S_SEND: begin
            if (tx_ready) begin
               st_nxt.rep_i = st_r.rep_i + 2'h1;
               if (st_r.rep_i == st_r.rep_last) begin
                  st_nxt.rep_i = 2'h0;
                  st_nxt.state = st_r.after;
               end
            end
         end
         S_PWLOAD, S_SUM: begin
            if (st_r.wt) begin
               st_nxt.wt = 1'b0;
               st_nxt.idx = st_r.idx + 19'h00001;
               st_nxt.stored[st_r.idx[3:0]] = flash_data_i;
               // unsigned byte added into 16 bits
               st_nxt.total = st_r.total + {8'h00, flash_data_i};
            end else if (st_r.rd) begin
               st_nxt.wt = 1'b1;
            end else if (st_r.state == S_PWLOAD && st_r.idx == PW_END) begin
               st_nxt.idx = '0;
               st_nxt.sum8 = '0;
               st_nxt.mism = 1'b0;
               st_nxt.rxerr = 1'b0;
               st_nxt.state = S_PWRX;
            // stop only after last flash byte
            end else if (st_r.state == S_SUM && st_r.idx == SUM_END) begin
               // total reply ends in check byte
               st_nxt.rep = {8'h00,
                             frame_check(st_r.total[15:8] + st_r.total[7:0]),
                             st_r.total[7:0], st_r.total[15:8]};
               st_nxt.rep_last = 2'h2;
               st_nxt.after = S_CMD;
               st_nxt.state = S_SEND;
            end else if (!flash_busy_i) begin
               st_nxt.rd = 1'b1;
               st_nxt.addr = (st_r.state == S_SUM) ?
                             FLASH_BASE + {5'h00, st_r.idx} :
                             PW_ADDR + {5'h00, st_r.idx};
            end
         end
         S_PWRX: begin
            if (rx_valid) begin
               st_nxt.idx = st_r.idx + 19'h00001;
               st_nxt.sum8 = add8;
               st_nxt.rxerr = st_r.rxerr | rx_err;
               if (st_r.idx[3:0] == 4'h0) begin
                  st_nxt.first = rx_data;
                  st_nxt.same = 1'b1;
               end else if (rx_data != st_r.first && st_r.idx[3:0] < PW_LAST) begin
                  st_nxt.same = 1'b0;
               end
               // compare in order with stored byte
               if (st_r.idx[3:0] < PW_LAST &&
                   rx_data != st_r.stored[st_r.idx[3:0]]) begin
                  st_nxt.mism = 1'b1;
               end
               // verdict goes back after the 13th byte, the check byte
               if (st_r.idx[3:0] == PW_LAST) begin
                  st_nxt.rep[0] = {st_r.cmd[7:4], ack_lo};
                  st_nxt.rep_last = 2'h0;
                  st_nxt.after = S_CMD;
                  st_nxt.state = S_SEND;
               end
            end
         end
         default: st_nxt.state = S_HALT;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.state <= S_BAUD;
         st_r.after <= S_CMD;
         st_r.bit_cyc <= MIN_BIT_CYCLES;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flash_addr_o = st_r.addr;
   assign flash_rd_o = st_r.rd;
   assign linked_o = (st_r.state != S_BAUD) && (st_r.state != S_HALT);
   assign halted_o = (st_r.state == S_HALT);

endmodule : boot_dev

// ==== verilog/boot_host.sv ====
// Controller end of the serial boot link
`timescale 1ns/100ps
module boot_host
   import boot_pkg::*;
#(
   parameter logic [BIT_W-1:0] BIT_CYCLES = 16'h1047
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   boot_link_if.host link,
   input wire logic go_i,
   input wire logic [7:0] cmd_i,
   input wire logic [8*PW_LEN-1:0] pw_i,
   output logic ready_o,
   output logic linked_o,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic rx_err_o
);

   typedef enum logic [5:0] {
      H_SYNC = 6'h01,
      H_WSYNC = 6'h02,
      H_IDLE = 6'h04,
      H_CMD = 6'h08,
      H_WECHO = 6'h10,
      H_PW = 6'h20
   } host_state_t;

   localparam logic [3:0] PW_LAST = 4'(PW_LEN);

   typedef struct packed {
      host_state_t state;
      logic [7:0] cmd;
      logic [PW_LEN-1:0][7:0] pw;
      logic [3:0] k;
      logic [7:0] sum8;
      logic linked;
   } host_regs_t;

   host_regs_t h_r, h_nxt;
   logic tx_ready, tx_valid;
   logic [7:0] tx_data;

   ////////////////////////////////////////////////////////////////////////
   // Serial engine at the fixed session rate
   uart_byte u_uart (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .bit_cycles_i(BIT_CYCLES),
      .rx_en_i(1'b1),
      .rxd_i(link.to_host),
      .tx_data_i(tx_data),
      .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready),
      .txd_o(link.to_dev),
      .rx_level_o(),
      .rx_data_o(rx_byte_o),
      .rx_valid_o(rx_valid_o),
      .rx_err_o(rx_err_o)
   );

   // Byte offered to the transmitter
   always_comb begin
      tx_valid = 1'b0;
      tx_data = h_r.cmd;
      if (h_r.state == H_SYNC) begin
         // sync byte first at session rate
         tx_valid = 1'b1;
         tx_data = SYNC_BYTE;
      end else if (h_r.state == H_CMD) begin
         tx_valid = 1'b1;
      end else if (h_r.state == H_PW) begin
         tx_valid = 1'b1;
         tx_data = (h_r.k == PW_LAST) ? frame_check(h_r.sum8) :
                   h_r.pw[h_r.k];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Session sequencer
   always_comb begin
      h_nxt = h_r;
      unique case (h_r.state)
         H_SYNC: begin
            if (tx_ready) begin
               h_nxt.state = H_WSYNC;
            end
         end
         H_WSYNC: begin
            if (rx_valid_o && !rx_err_o && rx_byte_o == SYNC_BYTE) begin
               h_nxt.linked = 1'b1;
               h_nxt.state = H_IDLE;
            end
         end
         H_IDLE: begin
            if (go_i) begin
               h_nxt.cmd = cmd_i;
               h_nxt.pw = pw_i;
               h_nxt.state = H_CMD;
            end
         end
         H_CMD: begin
            if (tx_ready) begin
               h_nxt.k = 4'h0;
               h_nxt.sum8 = 8'h00;
               h_nxt.state = (h_r.cmd == CMD_RAM || h_r.cmd == CMD_PROTECT) ?
                             H_WECHO : H_IDLE;
            end
         end
         H_WECHO: begin
            if (rx_valid_o) begin
               h_nxt.state = (rx_byte_o == h_r.cmd && !rx_err_o) ?
                             H_PW : H_IDLE;
            end
         end
         H_PW: begin
            if (tx_ready) begin
               h_nxt.k = h_r.k + 4'h1;
               h_nxt.sum8 = h_r.sum8 + h_r.pw[h_r.k];
               if (h_r.k == PW_LAST) begin
                  h_nxt.state = H_IDLE;
               end
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         h_r <= '0;
         h_r.state <= H_SYNC;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign ready_o = (h_r.state == H_IDLE);
   assign linked_o = h_r.linked;

endmodule : boot_host

// ==== tb/boot_serial_auth_frame_check_byte_chk.sv ====
// Checker for the serial link and the device flash port
`timescale 1ns/100ps
module boot_serial_auth_frame_check_byte_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic to_dev,
   input wire logic to_host,
   input wire logic flash_rd_o,
   input wire logic flash_busy_i,
   input wire logic [23:0] flash_addr_o,
   input wire logic linked_o,
   input wire logic halted_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   // Flash port behaviour
   rd_not_busy_a: assert property (flash_busy_i && $past(flash_busy_i)
      |-> !flash_rd_o) else $error("flash read while busy");
   rd_spacing_a: assert property (flash_rd_o |=> !flash_rd_o [*2])
      else $error("flash reads too close");
   addr_hold_a: assert property (flash_rd_o |=> $stable(flash_addr_o))
      else $error("flash address moved after read");
   addr_range_a: assert property (flash_rd_o
      |-> flash_addr_o[23:18] == 6'h01) else $error("read outside flash");
   ////////////////////////////////////////////////////////////////////////
   // Link behaviour
   halt_quiet_a: assert property (halted_o |-> to_host)
      else $error("halted device drives line");
   link_excl_a: assert property (linked_o |-> !halted_o)
      else $error("linked and halted together");
   reply_linked_a: assert property ($fell(to_host) |-> linked_o)
      else $error("reply before baud known");
   dev_start_a: assert property ($fell(to_host) |=> !to_host [*7])
      else $error("short device start bit");
   host_start_a: assert property ($fell(to_dev) |=> !to_dev [*7])
      else $error("short controller start bit");
   // Main scenarios reached
   link_up_c: cover property ($rose(linked_o));
   pw_read_c: cover property (flash_rd_o && flash_addr_o == 24'h04fef4);
   reply_c: cover property ($fell(to_host));
endmodule : boot_serial_auth_frame_check_byte_chk

// ==== tb/boot_serial_auth_frame_check_byte_tb.sv ====
// Testbench: controller and device ends joined over the link
`timescale 1ns/100ps
module boot_serial_auth_frame_check_byte_tb;
   import boot_pkg::*;
   logic clk_i, rst_n_i, go_i, flash_busy_i, flash_rd_o, ready_o;
   logic dev_linked, host_linked, halted_o, rx_valid_o, rx_err_o;
   logic [7:0] cmd_i, flash_data_i, rx_byte_o;
   logic [8*PW_LEN-1:0] pw_i;
   logic [23:0] flash_addr_o;
   logic [7:0] pmem [0:14];
   logic [7:0] got [0:3];
   int mismatches, checked;
   boot_link_if link();
   boot_dev #(.SUM_BYTES(16), .INFO_0(8'h3c), .INFO_1(8'hc3)) boot_dev_i (
      .clk_i, .rst_n_i, .link(link), .flash_addr_o, .flash_rd_o,
      .flash_data_i, .flash_busy_i, .linked_o(dev_linked), .halted_o);
   boot_host #(.BIT_CYCLES(16'h0010)) boot_host_i (.clk_i, .rst_n_i,
      .link(link), .go_i, .cmd_i, .pw_i, .ready_o, .linked_o(host_linked),
      .rx_byte_o, .rx_valid_o, .rx_err_o);
   boot_serial_auth_frame_check_byte_chk chk_i (.clk_i, .rst_n_i,
      .to_dev(link.to_dev), .to_host(link.to_host), .flash_rd_o,
      .flash_busy_i, .flash_addr_o, .linked_o(dev_linked), .halted_o);
   // Clock, 25 ns period
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Flash: password and vector area, counted data elsewhere
   always @(negedge clk_i) begin
      if (flash_addr_o >= PW_ADDR && flash_addr_o < PW_ADDR + 24'h00000f)
         flash_data_i <= pmem[flash_addr_o - PW_ADDR];
      else
         flash_data_i <= flash_addr_o[7:0] + 8'ha1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Issue one command, collect n reply bytes, flash busy for hold cycles
   task automatic run_cmd(input logic [7:0] c, input int n, input int hold);
      int k;
      k = 0;
      while (ready_o !== 1'b1 && k < 9000) begin
         @(negedge clk_i);
         k++;
      end
      if (k >= 9000) begin
         mismatches++;
         end_of_test();
      end
      cmd_i = c;
      go_i = 1'b1;
      flash_busy_i = (hold > 0);
      @(negedge clk_i);
      go_i = 1'b0;
      for (int i = 0; i < n; i++) begin
         for (k = 0; k < 9000 && rx_valid_o !== 1'b1; k++) begin
            @(negedge clk_i);
            if (k == hold) flash_busy_i = 1'b0;
         end
         if (k >= 9000) begin
            mismatches++;
            end_of_test();
         end
         got[i] = rx_byte_o;
         @(negedge clk_i);
      end
   endtask : run_cmd
   ////////////////////////////////////////////////////////////////////////
   // Sync byte measured and answered
   task automatic t_sync;
      for (int k = 0; k < 9000 && host_linked !== 1'b1; k++)
         @(negedge clk_i);
      if (host_linked !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      check({7'h00, dev_linked}, 8'h01);
      check({7'h00, halted_o}, 8'h00);
      check(rx_byte_o, SYNC_BYTE);
   endtask : t_sync
   // Correct password, then one wrong byte
   task automatic t_pw;
      for (int i = 0; i < 15; i++)
         pmem[i] = (i < 12) ? 8'h20 + 8'(i) : 8'h00;
      for (int i = 0; i < 12; i++)
         pw_i[8*i+:8] = pmem[i];
      run_cmd(CMD_PROTECT, 2, 0);
      check(got[0], 8'h60);
      check(got[1], 8'h60);
      pw_i[47:40] = pw_i[47:40] ^ 8'h01;
      run_cmd(CMD_RAM, 2, 0);
      check(got[0], 8'h10);
      check(got[1], 8'h11);
   endtask : t_pw
   // Uniform passwords: only the blank device passes
   task automatic t_uniform;
      logic [31:0] pv;
      logic [31:0] vv;
      pv = 32'h5affff00;
      vv = 32'h00ff0000;
      for (int j = 0; j < 4; j++) begin
         for (int i = 0; i < 15; i++)
            pmem[i] = (i < 12) ? pv[8*(3-j)+:8] : vv[8*(3-j)+:8];
         pw_i = {PW_LEN{pv[8*(3-j)+:8]}};
         run_cmd(CMD_PROTECT, 2, 0);
         check(got[1], {7'h30, j != 1});
      end
   endtask : t_uniform
   // Flash total with reads stalled by busy
   task automatic t_sum;
      logic [15:0] s;
      s = 16'h0000;
      for (int a = 0; a < 16; a++)
         s = s + 16'(8'(a) + 8'ha1);
      run_cmd(CMD_SUM, 4, 300);
      check(got[0], CMD_SUM);
      check(got[1], s[15:8]);
      check(got[2], s[7:0]);
      check(got[3], 8'h00 - (s[15:8] + s[7:0]));
   endtask : t_sum
   // Product information and an undefined command
   task automatic t_info;
      run_cmd(CMD_INFO, 4, 0);
      check(got[0], CMD_INFO);
      check(got[1], 8'h3c);
      check(got[2], 8'hc3);
      check(got[3], 8'h00 - (8'h3c + 8'hc3));
      run_cmd(8'h70, 1, 0);
      check(got[0], 8'h71);
      check({7'h00, rx_err_o}, 8'h00);
   endtask : t_info
   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      go_i = 1'b0;
      cmd_i = 8'h00;
      pw_i = '0;
      flash_busy_i = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_sync();
      t_pw();
      t_uniform();
      t_sum();
      t_info();
      end_of_test();
   end
endmodule : boot_serial_auth_frame_check_byte_tb
